//--- dv/dcb_core_assertions.sv
// Port assertions for the command and burst block
`timescale 1ns/100ps
module dcb_core_checker
  import dcb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports
  input wire logic csN,
  input wire logic beatValid,
  input wire logic beatReady,
  input wire dcb_beat_t beatOut,
  input wire logic [BANKS-1:0] bankOpen,
  input wire logic [MODE_W-1:0] operatingModeWord,
  input wire logic dllOn,
  input wire logic selfRefresh,
  input wire logic refreshPulse
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Long window: a command sampled just before deselect may still land
  property p_desel_open;
    csN [*8] |-> (bankOpen & ~$past(bankOpen)) == '0;
  endproperty
  a_desel_open: assert property (p_desel_open)
    else $error("bank opened while deselected");
  // Restart bit excluded, it clears by itself
  property p_desel_mode;
    csN [*8] |-> $stable(operatingModeWord[7:0])
      && $stable(operatingModeWord[MODE_W-1:9]);
  endproperty
  a_desel_mode: assert property (p_desel_mode)
    else $error("mode word changed while deselected");
  property p_ref_pulse;
    refreshPulse |=> !refreshPulse;
  endproperty
  a_ref_pulse: assert property (p_ref_pulse)
    else $error("refresh pulse longer than one cycle");
  property p_ref_idle;
    refreshPulse |-> bankOpen == '0;
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("refresh with a bank open");
  property p_self_dll;
    selfRefresh |-> !dllOn;
  endproperty
  a_self_dll: assert property (p_self_dll)
    else $error("delay loop on in self refresh");
  property p_exit_dll;
    $fell(selfRefresh) |-> ##[0:2] dllOn;
  endproperty
  a_exit_dll: assert property (p_exit_dll)
    else $error("delay loop not back on after exit");
  property p_dll_clear;
    operatingModeWord[DLL_RESTART_BIT] |->
      ##[1:4] !operatingModeWord[DLL_RESTART_BIT];
  endproperty
  a_dll_clear: assert property (p_dll_clear)
    else $error("restart bit did not clear");
  property p_hold;
    beatValid && !beatReady |=> beatValid && $stable(beatOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("beat lost or changed under stall");
endmodule

bind dcb_core dcb_core_checker dcb_core_checker_i (.clk_sys, .rst, .csN,
  .beatValid, .beatReady, .beatOut, .bankOpen, .operatingModeWord, .dllOn,
  .selfRefresh, .refreshPulse);

//--- dv/dcb_ctrl_model.sv
// Memory controller model driving the command pins
`timescale 1ns/100ps
module dcb_ctrl_model
  import dcb_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Command pins
  output dcb_pins_t pins
);
  initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 14'h0000};
  // ------
  // Command issue: held two cycles, then deselect and a gap
  // ------
  task automatic cmd(input logic [3:0] s, input logic [1:0] b,
      input logic [ROW_W-1:0] a, input logic k);
    @(posedge clk_sys);
    pins <= '{s[3], s[2], s[1], s[0], k, b, a};
    repeat (2) @(posedge clk_sys);
    // Released bank and address lines show the inverse; the strobes keep the last value
    pins <= '{1'b1, s[2], s[1], s[0], k, ~b, ~a};
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the command and burst block
`timescale 1ns/100ps
module tb_top
  import dcb_pkg::*;
;
  logic clk_sys, rst, beatReady, writeByteMask, beatValid;
  logic [DATA_W-1:0] wrData;
  logic [2:0] addedCommandDelay;
  dcb_pins_t pins;
  dcb_beat_t beatOut;
  dcb_beat_t q[$];
  logic [BANKS-1:0] bankOpen;
  logic [MODE_W-1:0] operatingModeWord;
  logic dllOn, selfRefresh, refreshPulse;
  logic [ROW_W-1:0] refreshRow;
  int num_errors = 0;
  int num_checks = 0;
  int refreshes = 0;

  dcb_ctrl_model dcb_ctrl_model_i (.clk_sys, .pins);
  dcb_core dcb_core_i (.clk_sys, .rst, .csN(pins.csN), .rasN(pins.rasN),
    .casN(pins.casN), .weN(pins.weN), .cke(pins.cke), .bank(pins.bank),
    .addr(pins.addr), .wrData, .writeByteMask, .addedCommandDelay,
    .beatValid, .beatReady, .beatOut, .bankOpen, .operatingModeWord,
    .dllOn, .selfRefresh, .refreshPulse, .refreshRow);

  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (beatValid === 1'b1 && beatReady === 1'b1) q.push_back(beatOut);
    if (refreshPulse === 1'b1) refreshes++;
  end
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] s, input logic [1:0] b,
      input logic [ROW_W-1:0] a, input logic k = 1'b1);
    dcb_ctrl_model_i.cmd(s, b, a, k);
  endtask
  function automatic logic [COL_W-1:0] ecol(logic [COL_W-1:0] s, int i,
      bit eight, bit inter);
    logic [2:0] lo;
    lo = inter ? s[2:0] ^ 3'(i) : {s[2] ^ i[2], s[1:0] + 2'(i)};
    if (!eight) lo[2] = s[2];
    return {s[COL_W-1:3], lo};
  endfunction
  task automatic burst(input logic [3:0] s, input logic [1:0] b,
      input logic [ROW_W-1:0] r, input logic [9:0] c, input logic ap,
      input int n, input bit inter);
    int w;
    q.delete();
    cmd(s, b, {3'h0, ap, c});
    for (w = 0; w < 80 && q.size() < n; w++) @(posedge clk_sys);
    chk(q.size(), n);
    foreach (q[i]) begin
      chk({q[i].bank, q[i].row, q[i].col},
          {b, r, ecol(c, i, n == 8, inter)});
      if (!s[0]) begin
        chk({q[i].write, q[i].mask, q[i].data},
            {1'b1, writeByteMask, wrData});
      end else begin
        chk(q[i].write, 1'b0);
      end
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_mode();
    chk(operatingModeWord, MODE_RESET);
    cmd(4'h0, MODE_SEL_MAIN, 14'h0103);
    chk(operatingModeWord, 17'h00003);
    cmd(4'h0, 2'h1, 14'h000A);
    chk(operatingModeWord, 17'h00003);
    done("mode");
  endtask
  task automatic t_rows();
    cmd(4'h3, 2'h1, 14'h1234);
    cmd(4'h3, 2'h2, 14'h0ABC);
    cmd(4'hB, 2'h3, 14'h0000);
    cmd(4'h7, 2'h0, 14'h0000);
    chk(bankOpen, 4'h6);
    done("rows");
  endtask
  task automatic t_burst();
    fork
      burst(4'h5, 2'h1, 14'h1234, 10'h0D5, 1'b0, 8, 0);
      begin
        repeat (8) @(posedge clk_sys);
        beatReady <= 1'b0;
        repeat (3) @(posedge clk_sys);
        beatReady <= 1'b1;
      end
    join
    chk(q[3].col, 10'h0D4);
    chk(q[4].col, 10'h0D1);
    wrData <= 8'hA5;
    writeByteMask <= 1'b1;
    burst(4'h4, 2'h2, 14'h0ABC, 10'h3F2, 1'b0, 8, 0);
    writeByteMask <= 1'b0;
    burst(4'h4, 2'h2, 14'h0ABC, 10'h007, 1'b0, 8, 0);
    chk(bankOpen, 4'h6);
    done("burst");
  endtask
  task automatic t_close();
    burst(4'h5, 2'h1, 14'h1234, 10'h100, 1'b1, 8, 0);
    repeat (8) @(posedge clk_sys);
    chk(bankOpen, 4'h4);
    cmd(4'h1, 2'h0, 14'h0000);
    cmd(4'h2, 2'h2, 14'h0000);
    cmd(4'h2, 2'h2, 14'h0000);
    chk(refreshes, 0);
    chk(bankOpen, 4'h0);
    cmd(4'h0, 2'h0, 14'h000A);
    addedCommandDelay <= 3'h3;
    cmd(4'h3, 2'h0, 14'h0055);
    burst(4'h5, 2'h0, 14'h0055, 10'h1FB, 1'b0, 4, 1);
    chk(q[1].col, 10'h1FA);
    cmd(4'h2, 2'h0, 14'h0400);
    chk(bankOpen, 4'h0);
    done("close");
  endtask
  task automatic t_refresh();
    logic [ROW_W-1:0] row0;
    row0 = refreshRow;
    cmd(4'h1, 2'h0, 14'h3FFF);
    chk(refreshes, 1);
    chk(refreshRow, 14'(row0 + 14'h0001));
    cmd(4'h1, 2'h0, 14'h0000, 1'b0);
    chk({selfRefresh, dllOn}, 2'b10);
    cmd(4'h7, 2'h0, 14'h0000, 1'b1);
    chk({selfRefresh, dllOn}, 2'b01);
    done("refresh");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run is near 250 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    beatReady = 1'b1;
    wrData = 8'h00;
    writeByteMask = 1'b0;
    addedCommandDelay = 3'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_mode();
    t_rows();
    t_burst();
    t_close();
    t_refresh();
    report_and_stop();
  end
endmodule

//--- hdl/dcb_core.sv
// Command decode, bank tracking, mode word and burst ordering
`timescale 1ns/100ps
// Functional notes
// - Chip select high ignores pins; running operations continue.
// - No-operation registers nothing and disturbs nothing.
// - Mode load picks register by bank inputs, data from address.
// - Activate opens row in bank until that bank is precharged.
// - Read starts burst from open row at given column.
// - Write starts burst into open row at given column.
// - Address bit ten selects auto precharge at burst end.
// - Added delay postpones read and write registration by cycles.
// - Mask low stores beat, mask high discards it.
// - Precharge closes one or all banks, idle after precharge time; here bankOpen clears at once and the timer gates nothing.
// - Precharge to idle or precharging bank restarts its period.
// - Access to another bank allowed during auto precharge.
// - Refresh with all idle; internal address; one per command.
// - Refresh with clock gate low enters self refresh.
// - Self refresh turns delay loop off; exit turns it on.
// - Mode load rewrites all fields; restart bit self clears.
// - Burst size field sets four or eight for both directions.
// - Burst wraps inside aligned block of burst size.
// - Order bit picks sequential or interleaved.
// - Sequential counts modulo four within nibble, repeats in other.
// - Interleaved index is start low bits xor beat count.
// - Activate, read, write, precharge decode from three strobes.
module dcb_core
  import dcb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command pins
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic cke,
  input wire logic [1:0] bank,
  input wire logic [ROW_W-1:0] addr,
  // Write data beside the command, one per beat
  input wire logic [DATA_W-1:0] wrData,
  input wire logic writeByteMask,
  // Added command delay in cycles
  input wire logic [2:0] addedCommandDelay,
  // Beat stream to array
  output logic beatValid,
  input wire logic beatReady,
  output dcb_beat_t beatOut,
  // Status
  output logic [BANKS-1:0] bankOpen,
  output logic [MODE_W-1:0] operatingModeWord,
  output logic dllOn,
  output logic selfRefresh,
  output logic refreshPulse,
  output logic [ROW_W-1:0] refreshRow
);
  // ----------------------------------------------------------
  // Pin sampling (three stages, change on agreement)
  // ----------------------------------------------------------
  dcb_pins_t pinNow;
  dcb_pins_t s1Q, s2Q, s3Q, pinQ;
  assign pinNow = '{csN, rasN, casN, weN, cke, bank, addr};
  logic [DATA_W-1:0] d1Q, d2Q;
  logic m1Q, m2Q;
  logic newQ;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1Q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
               cke: 1'b1, default: '0};
      s2Q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
               cke: 1'b1, default: '0};
      s3Q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
               cke: 1'b1, default: '0};
      pinQ <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
                cke: 1'b1, default: '0};
      d1Q <= '0;
      d2Q <= '0;
      m1Q <= 1'b1;
      m2Q <= 1'b1;
      newQ <= 1'b0;
    end else begin
      s1Q <= pinNow;
      s2Q <= s1Q;
      s3Q <= s2Q;
      d1Q <= wrData;
      d2Q <= d1Q;
      m1Q <= writeByteMask;
      m2Q <= m1Q;
      if (s2Q == s3Q) begin
        pinQ <= s3Q;
      end
      // One decode per settled change: a command held for several
      // cycles runs once, but two equal commands need a gap between
      newQ <= (s2Q == s3Q) && (s3Q != pinQ);
    end
  end

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  dcb_cmd_t cmd;
  logic isLoad, isRefresh;
  always_comb begin
    cmd = CMD_NONE;
    isLoad = 1'b0;
    isRefresh = 1'b0;
    if (!pinQ.csN && newQ) begin
      unique case ({pinQ.rasN, pinQ.casN, pinQ.weN})
        3'b011: cmd = CMD_ACT;
        3'b101: cmd = CMD_RD;
        3'b100: cmd = CMD_WR;
        3'b010: cmd = CMD_PRE;
        3'b000: begin
          cmd = CMD_OTH;
          isLoad = 1'b1;
        end
        3'b001: begin
          cmd = CMD_OTH;
          isRefresh = 1'b1;
        end
        default: cmd = CMD_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------
  logic [MODE_W-1:0] mode_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_RESET;
    end else if (isLoad && pinQ.bank == MODE_SEL_MAIN) begin
      // Whole word replaced; upper bits zero-filled
      mode_q <= {{(MODE_W-ROW_W){1'b0}}, pinQ.addr};
    end else begin
      mode_q[DLL_RESTART_BIT] <= 1'b0;
    end
  end
  assign operatingModeWord = mode_q;
  // Reserved size codes fall back to four
  logic eight;
  assign eight = (mode_q[BSZ_LSB +: 3] == BSZ_EIGHT);
  logic interleave;
  assign interleave = mode_q[ORDER_BIT];

  // ----------------------------------------------------------
  // Bank state: open rows and precharge timers
  // ----------------------------------------------------------
  logic [ROW_W-1:0] rowQ [BANKS];
  logic [3:0] preCntQ [BANKS];
  logic [BANKS-1:0] openQ;
  logic [BANKS-1:0] apReq;
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      logic hitPre;
      assign hitPre = (cmd == CMD_PRE) &&
                      (pinQ.addr[AP_BIT] || pinQ.bank == gb);
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          openQ[gb] <= 1'b0;
          rowQ[gb] <= '0;
          preCntQ[gb] <= '0;
        end else begin
          if (hitPre || apReq[gb]) begin
            openQ[gb] <= 1'b0;
            preCntQ[gb] <= PRE_CYC;
          end else if (cmd == CMD_ACT && pinQ.bank == gb) begin
            openQ[gb] <= 1'b1;
            rowQ[gb] <= pinQ.addr;
          end else if (preCntQ[gb] != 4'h0) begin
            preCntQ[gb] <= preCntQ[gb] - 4'h1;
          end
        end
      end
    end
  endgenerate
  assign bankOpen = openQ;

  // ----------------------------------------------------------
  // Refresh, self refresh and delay loop
  // ----------------------------------------------------------
  logic selfQ, dllQ, refQ;
  logic [ROW_W-1:0] refRowQ;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selfQ <= 1'b0;
      dllQ <= 1'b1;
      refQ <= 1'b0;
      refRowQ <= '0;
    end else begin
      refQ <= 1'b0;
      if (selfQ) begin
        if (pinQ.cke) begin
          selfQ <= 1'b0;
          dllQ <= 1'b1;
        end
      end else if (isRefresh && openQ == '0) begin
        refQ <= pinQ.cke;
        refRowQ <= refRowQ + 14'h0001;
        if (!pinQ.cke) begin
          selfQ <= 1'b1;
          dllQ <= 1'b0;
        end
      end
    end
  end
  assign selfRefresh = selfQ;
  assign dllOn = dllQ;
  assign refreshPulse = refQ;
  assign refreshRow = refRowQ;

  // ----------------------------------------------------------
  // Added delay line for read and write
  // ----------------------------------------------------------
  typedef struct packed {
    logic vld;
    logic wr;
    logic ap;
    logic [1:0] bank;
    logic [COL_W-1:0] col;
  } dcb_acc_t;
  dcb_acc_t dlyQ [DELAY_MAX+1];
  dcb_acc_t accNow, accOut;
  assign accNow = '{vld: (cmd == CMD_RD || cmd == CMD_WR),
                    wr: (cmd == CMD_WR), ap: pinQ.addr[AP_BIT],
                    bank: pinQ.bank, col: pinQ.addr[COL_W-1:0]};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i <= DELAY_MAX; i++) begin
        dlyQ[i] <= '0;
      end
    end else begin
      dlyQ[0] <= accNow;
      for (int i = 1; i <= DELAY_MAX; i++) begin
        dlyQ[i] <= dlyQ[i-1];
      end
    end
  end
  assign accOut = (addedCommandDelay == 3'h0) ? accNow :
                  dlyQ[addedCommandDelay - 3'h1];

  // ----------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------
  dcb_state_t stQ;
  dcb_acc_t curQ;
  logic [2:0] beatQ;
  logic bufReady;
  logic [2:0] idx;
  logic lastBeat;
  always_comb begin
    if (interleave) begin
      idx = curQ.col[2:0] ^ beatQ;
    end else begin
      idx = {curQ.col[2] ^ beatQ[2],
             2'(curQ.col[1:0] + beatQ[1:0])};
    end
    if (!eight) begin
      idx[2] = curQ.col[2];
    end
  end
  assign lastBeat = (beatQ == (eight ? 3'h7 : 3'h3));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stQ <= BST_IDLE;
      curQ <= '0;
      beatQ <= '0;
    end else begin
      unique case (stQ)
        BST_IDLE: begin
          if (accOut.vld) begin
            curQ <= accOut;
            beatQ <= '0;
            stQ <= BST_RUN;
          end else if (selfQ) begin
            stQ <= BST_SELF;
          end
        end
        BST_RUN: begin
          if (bufReady) begin
            if (lastBeat) begin
              // New access (same or other bank) chains directly
              if (accOut.vld) begin
                curQ <= accOut;
                beatQ <= '0;
              end else begin
                stQ <= BST_IDLE;
              end
            end else begin
              beatQ <= beatQ + 3'h1;
            end
          end
        end
        BST_SELF: begin
          if (!selfQ) begin
            stQ <= BST_IDLE;
          end
        end
      endcase
    end
  end
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_ap
      assign apReq[gb] = (stQ == BST_RUN) && bufReady && lastBeat &&
                         curQ.ap && (curQ.bank == gb);
    end
  endgenerate

  // ----------------------------------------------------------
  // Two-entry beat buffer toward the array
  // ----------------------------------------------------------
  // A command arriving while stalled can be dropped; the controller
  // must keep beatReady high in practice.
  dcb_beat_t bufQ [2];
  logic [1:0] cntQ;
  logic validQ;
  logic push, pop;
  dcb_beat_t beatNow;
  assign bufReady = (cntQ != 2'h2);
  assign push = (stQ == BST_RUN) && bufReady;
  assign pop = (cntQ != 2'h0) && beatReady;
  assign beatNow = '{write: curQ.wr, bank: curQ.bank,
                     row: rowQ[curQ.bank],
                     col: {curQ.col[COL_W-1:3], idx},
                     mask: curQ.wr & m2Q, data: d2Q};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bufQ[0] <= '0;
      bufQ[1] <= '0;
      cntQ <= '0;
      validQ <= 1'b0;
    end else begin
      // Head entry feeds the port, so beatOut leaves a flop directly
      if (pop) begin
        bufQ[0] <= (push && cntQ == 2'h1) ? beatNow : bufQ[1];
      end else if (push) begin
        bufQ[cntQ[0]] <= beatNow;
      end
      cntQ <= cntQ + {1'b0, push} - {1'b0, pop};
      validQ <= (cntQ + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end
  assign beatValid = validQ;
  assign beatOut = bufQ[0];
endmodule

//--- hdl/dcb_pkg.sv
// Package of constants and types for the DDR2 command and burst block
package dcb_pkg;
  localparam int BANKS = 4;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int MODE_W = 17;
  localparam int DATA_W = 8;
  // Mode word field positions and the auto precharge address bit
  localparam int BSZ_LSB = 0;
  localparam int ORDER_BIT = 3;
  localparam int DLL_RESTART_BIT = 8;
  localparam int AP_BIT = 10;
  // Burst size codes
  localparam logic [2:0] BSZ_FOUR = 3'h2;
  localparam logic [2:0] BSZ_EIGHT = 3'h3;
  // Mode register selected by bank inputs
  localparam logic [1:0] MODE_SEL_MAIN = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RESET = 17'h00002;
  // Cycle counts
  localparam logic [3:0] PRE_CYC = 4'h4;
  localparam logic [2:0] DELAY_MAX = 3'h6;

  typedef enum logic [4:0] {
    CMD_NONE = 5'h00,
    CMD_ACT = 5'h01,
    CMD_RD = 5'h02,
    CMD_WR = 5'h04,
    CMD_PRE = 5'h08,
    CMD_OTH = 5'h10
  } dcb_cmd_t;

  typedef enum logic [2:0] {
    BST_IDLE = 3'h1,
    BST_RUN = 3'h2,
    BST_SELF = 3'h4
  } dcb_state_t;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic cke;
    logic [1:0] bank;
    logic [ROW_W-1:0] addr;
  } dcb_pins_t;

  typedef struct packed {
    logic write;
    logic [1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic mask;
    logic [DATA_W-1:0] data;
  } dcb_beat_t;
endpackage
